// >>> hdl/uirq_pkg.sv
// package: register map, field layout and reset values of the serial port
`default_nettype none
package uirq_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_RX_DATA = 8'h00;
   localparam logic [7:0] OFS_RAW = 8'h04;
   localparam logic [7:0] OFS_MASKED = 8'h08;
   localparam logic [7:0] OFS_ENABLE = 8'h0c;
   localparam logic [7:0] OFS_CLEAR = 8'h10;
   localparam logic [7:0] OFS_BAUD = 8'h14;
   localparam logic [7:0] OFS_RATE = 8'h18;
   localparam logic [7:0] OFS_MIN_PULSE = 8'h28;
   localparam logic [7:0] OFS_RX_LEVEL = 8'h2c;
   // ------------------------------------------------------------
   // interrupt source positions
   // ------------------------------------------------------------
   localparam int NUM_IRQ = 19;
   localparam int B_RX_QUEUE_FULL = 0;
   localparam int B_TX_QUEUE_EMPTY = 1;
   localparam int B_RX_PARITY_FAULT = 2;
   localparam int B_FRAMING_FAULT = 3;
   localparam int B_RX_QUEUE_OVERFLOW = 4;
   localparam int B_SET_READY_CHANGE = 5;
   localparam int B_CLEAR_TO_SEND_CHANGE = 6;
   localparam int B_BREAK_SEEN = 7;
   localparam int B_RX_QUEUE_TIMEOUT = 8;
   localparam int B_RESUME_CHAR = 9;
   localparam int B_PAUSE_CHAR = 10;
   localparam int B_SHORT_PULSE = 11;
   localparam int B_BREAK_SENT = 12;
   localparam int B_POST_BREAK_IDLE = 13;
   localparam int B_TX_DONE = 14;
   localparam int B_BUS_PARITY_FAULT = 15;
   localparam int B_BUS_FRAMING_FAULT = 16;
   localparam int B_BUS_COLLISION = 17;
   localparam int B_ESCAPE_SEQ = 18;
   // ------------------------------------------------------------
   // baud divider and rate-detect fields
   // ------------------------------------------------------------
   localparam int DIV_INT_W = 20;
   localparam int DIV_INT_LSB = 0;
   localparam int DIV_FRAC_W = 4;
   localparam int DIV_FRAC_LSB = 20;
   localparam int RATE_EN_BIT = 0;
   localparam int FILT_W = 8;
   localparam int FILT_LSB = 8;
   localparam int PULSE_W = 20;
   localparam logic [DIV_INT_W-1:0] DIV_INT_RST = 20'h000d9;
   localparam logic [DIV_FRAC_W-1:0] DIV_FRAC_RST = 4'h0;
   localparam logic [FILT_W-1:0] FILT_RST = 8'h10;
   localparam logic [NUM_IRQ-1:0] ENABLE_RST = 19'h00000;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } uirq_byte_s;
   typedef struct packed {
      logic [DIV_FRAC_W-1:0] frac;
      logic [DIV_INT_W-1:0] whole;
   } uirq_div_s;
endpackage : uirq_pkg
`default_nettype wire

// >>> hdl/uirq_baud_gen.sv
// fractional baud divider producing a one-cycle bit-rate enable
`default_nettype none
module uirq_baud_gen
   import uirq_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic arst_n, // async reset
   input wire uirq_div_s div, // divider setting
   output logic baud_tick // one pulse per bit period
);
   logic [DIV_INT_W-1:0] cnt_r;
   logic [DIV_FRAC_W-1:0] acc_r;
   logic stretch_r;
   logic [DIV_FRAC_W:0] acc_sum;
   logic [DIV_INT_W-1:0] limit;
   logic wrap;

   // a carry out of the fraction stretches the next period by one cycle
   assign acc_sum = {1'b0, acc_r} + {1'b0, div.frac};
   assign limit = stretch_r ? div.whole : div.whole - 20'h00001;
   // zero divider stops the tick rather than spinning every cycle
   assign wrap = (div.whole != '0) && (cnt_r >= limit);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
      end else if (wrap || div.whole == '0) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 20'h00001;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= '0;
         stretch_r <= 1'b0;
      end else if (wrap) begin
         acc_r <= acc_sum[DIV_FRAC_W-1:0];
         stretch_r <= acc_sum[DIV_FRAC_W];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= wrap;
      end
   end
endmodule : uirq_baud_gen
`default_nettype wire

// >>> hdl/uirq_regs.sv
// serial port register front end: rx data port, interrupts, baud, autobaud
// Operation
// - read of offset 0x0 returns rx byte
// - raw status shows every pending source
// - masked status at 0x8, same positions
// - enable register read/write per source
// - writing one at 0x10 clears raw bit
// - transmit done source with full bit set
// - break sent and post-break idle sources
// - framing fault source for received characters
// - parity fault source for received characters
// - short pulse source on glitch detection
// - transmit queue empty interrupt source
// - baud register holds integer and fraction
// - fraction adds sub-cycle step to divider
// - autobaud ignores pulses below filter threshold
// - enable bit switches rate detection
`default_nettype none
module uirq_regs
   import uirq_pkg::*;
#(
   parameter int FIFO_DEPTH = 16, // rx byte queue depth
   parameter int FIFO_AW = 4 // log2 of depth
) (
   input wire logic mclk, // core clock 25 MHz
   input wire logic arst_n, // async reset, active low
   input wire logic [7:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire uirq_byte_s rx_push, // byte from receive engine
   output logic rx_queue_full, // no room for rx_push
   input wire logic [NUM_IRQ-1:0] src_event, // one-cycle source events
   input wire logic rxd_pin, // serial input pin, async
   output uirq_div_s baud_div, // current divider setting
   output logic baud_tick, // bit-rate enable pulse
   output logic rate_detect_on, // autobaud enabled
   output logic irq // level interrupt
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [NUM_IRQ-1:0] raw_r;
   logic [NUM_IRQ-1:0] ena_r;
   logic [NUM_IRQ-1:0] masked;
   logic [NUM_IRQ-1:0] clr_bits;
   logic [NUM_IRQ-1:0] events;
   logic [31:0] be_mask;
   logic [DIV_INT_W-1:0] div_int_r;
   logic [DIV_FRAC_W-1:0] div_frac_r;
   logic rate_en_r;
   logic [FILT_W-1:0] filt_r;
   logic [PULSE_W-1:0] min_pulse_r;
   logic [7:0] fifo_mem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wr_ptr_r;
   logic [FIFO_AW-1:0] rd_ptr_r;
   logic [FIFO_AW:0] level_r;
   logic rd_ack_r;
   logic rd_take;
   logic wr_take;
   logic pop;
   logic push;
   logic overflow_ev;
   logic fifo_empty;
   logic [31:0] rd_word;
   logic rx_meta_r;
   logic rx_sync_r;
   logic rx_prev_r;
   logic [PULSE_W-1:0] run_r;
   logic edge_seen;
   logic glitch_ev;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // ------------------------------------------------------------
   // avalon slave
   // ------------------------------------------------------------
   // reads wait one cycle so the data word comes from a flop;
   // writes are taken at once
   assign avs_waitrequest = avs_read & ~rd_ack_r;
   assign rd_take = avs_read & ~rd_ack_r;
   assign wr_take = avs_write;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_ack_r <= 1'b0;
      end else begin
         rd_ack_r <= rd_take;
      end
   end

   always_comb begin
      rd_word = 32'h00000000;
      case (avs_address)
         OFS_RX_DATA: rd_word = {24'h000000, fifo_mem[rd_ptr_r]};
         OFS_RAW: rd_word = {{(32-NUM_IRQ){1'b0}}, raw_r};
         OFS_MASKED: rd_word = {{(32-NUM_IRQ){1'b0}}, masked};
         OFS_ENABLE: rd_word = {{(32-NUM_IRQ){1'b0}}, ena_r};
         OFS_CLEAR: rd_word = 32'h00000000;
         OFS_BAUD: rd_word = {8'h00, div_frac_r, div_int_r};
         OFS_RATE: rd_word = {16'h0000, filt_r, 7'h00, rate_en_r};
         OFS_MIN_PULSE: rd_word = {12'h000, min_pulse_r};
         OFS_RX_LEVEL: rd_word = {{(31-FIFO_AW){1'b0}}, level_r};
         default: rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (rd_take) begin
         avs_readdata <= rd_word;
      end
   end

   // ------------------------------------------------------------
   // receive byte queue
   // ------------------------------------------------------------
   assign fifo_empty = (level_r == '0);
   assign rx_queue_full = (level_r == (FIFO_AW+1)'(FIFO_DEPTH));
   assign push = rx_push.valid & ~rx_queue_full;
   // an empty queue still answers, but the pointer stays put
   assign pop = rd_take & hit(avs_address, OFS_RX_DATA) & ~fifo_empty;
   assign overflow_ev = rx_push.valid & rx_queue_full;

   always_ff @(posedge mclk) begin
      if (push) begin
         fifo_mem[wr_ptr_r] <= rx_push.data;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         level_r <= '0;
      end else if (push && !pop) begin
         level_r <= level_r + 1'b1;
      end else if (pop && !push) begin
         level_r <= level_r - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // interrupt set
   // ------------------------------------------------------------
   always_comb begin
      events = src_event;
      events[B_SHORT_PULSE] = src_event[B_SHORT_PULSE] | glitch_ev;
      events[B_RX_QUEUE_OVERFLOW] = src_event[B_RX_QUEUE_OVERFLOW]
                                    | overflow_ev;
   end

   assign be_mask = lane_mask(avs_byteenable);
   assign clr_bits = (wr_take && hit(avs_address, OFS_CLEAR))
                     ? avs_writedata[NUM_IRQ-1:0]
                       & be_mask[NUM_IRQ-1:0]
                     : '0;

   // the set term is ORed last, so a same-cycle event survives its clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         raw_r <= '0;
      end else begin
         raw_r <= (raw_r & ~clr_bits) | events;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ena_r <= ENABLE_RST;
      end else if (wr_take && hit(avs_address, OFS_ENABLE)) begin
         ena_r <= (ena_r & ~be_mask[NUM_IRQ-1:0])
                  | (avs_writedata[NUM_IRQ-1:0]
                     & be_mask[NUM_IRQ-1:0]);
      end
   end

   assign masked = raw_r & ena_r;
   assign irq = |masked;

   // ------------------------------------------------------------
   // baud divider
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_int_r <= DIV_INT_RST;
         div_frac_r <= DIV_FRAC_RST;
      end else if (wr_take && hit(avs_address, OFS_BAUD)) begin
         if (avs_byteenable[0]) begin
            div_int_r[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            div_int_r[15:8] <= avs_writedata[15:8];
         end
         if (avs_byteenable[2]) begin
            div_int_r[19:16] <= avs_writedata[19:16];
            div_frac_r <= avs_writedata[DIV_FRAC_LSB +: DIV_FRAC_W];
         end
      end
   end

   assign baud_div.whole = div_int_r;
   assign baud_div.frac = div_frac_r;

   uirq_baud_gen u_baud (
      .mclk(mclk),
      .arst_n(arst_n),
      .div(baud_div),
      .baud_tick(baud_tick)
   );

   // ------------------------------------------------------------
   // rate detection
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rate_en_r <= 1'b0;
         filt_r <= FILT_RST;
      end else if (wr_take && hit(avs_address, OFS_RATE)) begin
         if (avs_byteenable[0]) begin
            rate_en_r <= avs_writedata[RATE_EN_BIT];
         end
         if (avs_byteenable[1]) begin
            filt_r <= avs_writedata[FILT_LSB +: FILT_W];
         end
      end
   end

   assign rate_detect_on = rate_en_r;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         rx_meta_r <= rxd_pin;
         rx_sync_r <= rx_meta_r;
         rx_prev_r <= rx_sync_r;
      end
   end

   assign edge_seen = rx_sync_r ^ rx_prev_r;
   // a pulse narrower than the filter raises the glitch event only
   assign glitch_ev = rate_en_r & edge_seen
                      & (run_r < {12'h000, filt_r});

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         run_r <= '0;
      end else if (!rate_en_r || edge_seen) begin
         run_r <= 20'h00001;
      end else if (run_r != '1) begin
         run_r <= run_r + 20'h00001;
      end
   end

   // shortest accepted low pulse; set to all ones by switching detection off
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         min_pulse_r <= '1;
      end else if (!rate_en_r) begin
         min_pulse_r <= '1;
      end else if (edge_seen && rx_sync_r && !glitch_ev
                   && run_r < min_pulse_r) begin
         min_pulse_r <= run_r;
      end
   end
endmodule : uirq_regs
`default_nettype wire

// >>> verification/uirq_regs_sva.sv
// checker for the serial port register block ports
`default_nettype none
module uirq_regs_chk
   import uirq_pkg::*;
#(
   parameter int FIFO_DEPTH = 16, // queue depth
   parameter int FIFO_AW = 4 // depth log2
) (
   input wire logic mclk, // clock
   input wire logic arst_n, // reset
   input wire logic [7:0] avs_address, // address
   input wire logic avs_read, // read
   input wire logic avs_write, // write
   input wire logic [31:0] avs_writedata, // wdata
   input wire logic [3:0] avs_byteenable, // lanes
   input wire logic [31:0] avs_readdata, // rdata
   input wire logic avs_waitrequest, // stall
   input wire uirq_byte_s rx_push, // push
   input wire logic rx_queue_full, // full
   input wire logic [NUM_IRQ-1:0] src_event, // events
   input wire logic rxd_pin, // line
   input wire uirq_div_s baud_div, // divider
   input wire logic baud_tick, // tick
   input wire logic rate_detect_on, // autobaud on
   input wire logic irq // interrupt
);
   logic [NUM_IRQ-1:0] en_r; // shadow enable, whole-word writes only
   logic [31:0] wd_r;
   logic wr_f;
   assign wr_f = avs_write && avs_byteenable == 4'hf;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         en_r <= ENABLE_RST;
         wd_r <= 32'h0;
      end else begin
         wd_r <= avs_writedata;
         if (wr_f && avs_address == OFS_ENABLE) begin
            en_r <= avs_writedata[NUM_IRQ-1:0];
         end
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   property p_rd_wait;
      $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait");
   property p_clr_zero;
      avs_read && !avs_waitrequest && avs_address == OFS_CLEAR
         |-> avs_readdata == 32'h0;
   endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("clr rd");
   property p_div_wr;
      wr_f && avs_address == OFS_BAUD |=> baud_div == wd_r[23:0];
   endproperty
   a_div_wr: assert property (p_div_wr) else $error("div wr");
   property p_rate_wr;
      wr_f && avs_address == OFS_RATE
         |=> rate_detect_on == wd_r[RATE_EN_BIT];
   endproperty
   a_rate_wr: assert property (p_rate_wr) else $error("rate wr");
   property p_tick_zero;
      baud_div.whole == 20'h0 [*3] |-> !baud_tick;
   endproperty
   a_tick_zero: assert property (p_tick_zero) else $error("tick");
   property p_tick_gap;
      baud_tick && baud_div.whole > 20'h1 && !avs_write |=> !baud_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("gap");
   property p_ev_irq;
      |(src_event & en_r) && !avs_write |=> irq;
   endproperty
   a_ev_irq: assert property (p_ev_irq) else $error("no irq");
   property p_mask_off;
      en_r == '0 |-> !irq;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq");
   property p_pop;
      avs_read && avs_waitrequest && avs_address == OFS_RX_DATA
         && rx_queue_full && !rx_push.valid |=> !rx_queue_full;
   endproperty
   a_pop: assert property (p_pop) else $error("no pop");
   property p_hold_full;
      rx_queue_full && !avs_read |=> rx_queue_full;
   endproperty
   a_hold_full: assert property (p_hold_full) else $error("full");
   c_irq: cover property (!irq ##1 irq);
   c_pop: cover property (avs_read && rx_queue_full);
   c_tick: cover property (baud_tick ##4 baud_tick);
endmodule : uirq_regs_chk
bind uirq_regs uirq_regs_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW))
   u_chk (.mclk, .arst_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .rx_push, .rx_queue_full, .src_event, .rxd_pin, .baud_div,
   .baud_tick, .rate_detect_on, .irq);
`default_nettype wire

// >>> verification/uirq_line_model.sv
// remote serial party: drives the line and hands in received bytes
`default_nettype none
module uirq_line_model
   import uirq_pkg::*;
(
   input wire logic mclk, // core clock
   output logic rxd_pin, // serial line, idles high
   output uirq_byte_s rx_push // received byte pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rxd_pin = 1'b1;
      rx_push = '0;
   end
   task automatic low_pulse(input int n);
      @(posedge mclk);
      rxd_pin <= 1'b0;
      repeat (n) @(posedge mclk);
      rxd_pin <= 1'b1;
   endtask : low_pulse
   task automatic send(input logic [7:0] b);
      @(posedge mclk);
      rx_push <= {1'b1, b};
      @(posedge mclk);
      // stale data inverted so nothing leans on it
      rx_push <= {1'b0, ~b};
   endtask : send
endmodule : uirq_line_model
`default_nettype wire

// >>> verification/uirq_regs_tb_top.sv
// testbench of the serial port register block
`default_nettype none
module uirq_regs_tb_top;
   import uirq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, arst_n, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, d, e;
   logic [3:0] avs_byteenable;
   uirq_byte_s rx_push;
   uirq_div_s baud_div;
   logic rx_queue_full, rxd_pin, baud_tick, rate_detect_on, irq;
   logic [NUM_IRQ-1:0] src_event;
   int errors, n_checks, cyc, c;
   uirq_regs #(.FIFO_DEPTH(16), .FIFO_AW(4)) dut (.mclk, .arst_n,
      .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_push,
      .rx_queue_full, .src_event, .rxd_pin, .baud_div, .baud_tick,
      .rate_detect_on, .irq);
   uirq_line_model u_line (.mclk, .rxd_pin, .rx_push);
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      q = avs_readdata;
      avs_read <= 1'b0;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      rd(a, d);
      chk($sformatf("reg %h", a), d, x);
   endtask : rchk
   // event pulse rides along the write so clear and set can coincide
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [NUM_IRQ-1:0] ev);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      src_event <= ev;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      avs_write <= 1'b0;
      src_event <= '0;
   endtask : wr
   task automatic ticks(input int n);
      c = 0;
      while (baud_tick !== 1'b1) @(posedge mclk);
      repeat (n) begin
         @(posedge mclk);
         c++;
         while (baud_tick !== 1'b1) begin
            @(posedge mclk);
            c++;
         end
      end
   endtask : ticks
   initial begin
      {arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {cyc, errors, n_checks, src_event} = '0;
      avs_byteenable = 4'hf;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      rchk(OFS_BAUD, 32'h000000d9);
      rchk(OFS_RATE, 32'h00001000);
      rchk(OFS_ENABLE, 32'h0);
      rchk(8'h40, 32'h0);
      wr(OFS_ENABLE, 32'h0007ffff, '0);
      rchk(OFS_ENABLE, 32'h0007ffff);
      wr(OFS_RAW, 32'hffffffff, '0);
      rchk(OFS_RAW, 32'h0);
      for (int i = 0; i < NUM_IRQ; i++) begin
         e = 32'h1 << i;
         wr(8'h40, 32'h0, e[NUM_IRQ-1:0]);
         rchk(OFS_RAW, e);
         rchk(OFS_MASKED, e);
         chk("irq", irq, 1'b1);
         wr(OFS_CLEAR, 32'h0, '0);
         rchk(OFS_RAW, e);
         wr(OFS_CLEAR, e, '0);
         rchk(OFS_RAW, 32'h0);
         chk("irq", irq, 1'b0);
      end
      rchk(OFS_CLEAR, 32'h0);
      wr(OFS_ENABLE, 32'h0007bfff, 19'h04000);
      rchk(OFS_MASKED, 32'h0);
      chk("irq", irq, 1'b0);
      wr(OFS_CLEAR, 32'h4000, 19'h04000);
      rchk(OFS_RAW, 32'h4000);
      wr(OFS_CLEAR, 32'h4000, '0);
      for (int i = 0; i < 16; i++) u_line.send(8'ha0 + 8'(i));
      @(posedge mclk);
      chk("full", rx_queue_full, 1'b1);
      u_line.send(8'h55);
      rchk(OFS_RAW, 32'h1 << B_RX_QUEUE_OVERFLOW);
      for (int i = 0; i < 16; i++) begin
         rd(OFS_RX_DATA, d);
         chk("rx byte", d[7:0], 8'ha0 + 8'(i));
      end
      rd(OFS_RX_DATA, d);
      rchk(OFS_RX_LEVEL, 32'h0);
      u_line.send(8'h3c);
      rd(OFS_RX_DATA, d);
      chk("rx after empty", d[7:0], 8'h3c);
      wr(OFS_CLEAR, 32'h0007ffff, '0);
      foreach (e[i]) if (i < 3) begin
         c = (i == 0) ? 0 : (i == 1) ? 8 : 5;
         wr(OFS_BAUD, {8'h0, c[3:0], 20'h4}, '0);
         rchk(OFS_BAUD, {8'h0, c[3:0], 20'h4});
         e = 32'(64 + c);
         ticks(16);
         chk("16 bit periods", c, e);
      end
      @(posedge mclk) avs_byteenable <= 4'h1;
      wr(OFS_BAUD, 32'h00fff0ab, '0);
      @(posedge mclk) avs_byteenable <= 4'hf;
      rchk(OFS_BAUD, 32'h000000ab);
      wr(OFS_BAUD, 32'h0, '0);
      repeat (4) @(posedge mclk);
      c = 0;
      repeat (20) @(posedge mclk) c += int'(baud_tick);
      chk("ticks stopped", c, 0);
      wr(OFS_RATE, 32'h1001, '0);
      @(posedge mclk);
      chk("rate on", rate_detect_on, 1'b1);
      u_line.low_pulse(5);
      repeat (6) @(posedge mclk);
      rchk(OFS_RAW, 32'h1 << B_SHORT_PULSE);
      wr(OFS_CLEAR, 32'h0007ffff, '0);
      repeat (20) @(posedge mclk);
      u_line.low_pulse(40);
      repeat (6) @(posedge mclk);
      rchk(OFS_RAW, 32'h0);
      rd(OFS_MIN_PULSE, d);
      chk("min pulse", d, 32'd40);
      wr(OFS_RATE, 32'h1000, '0);
      @(posedge mclk);
      chk("rate off", rate_detect_on, 1'b0);
      u_line.low_pulse(5);
      repeat (6) @(posedge mclk);
      rchk(OFS_RAW, 32'h0);
      wrap_up();
   end
endmodule : uirq_regs_tb_top
`default_nettype wire
